// ==== logic/emtc_pkg.sv ====
package emtc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   // longest settle time of the error flag after data reaches the corrector
   localparam int T_DATA_TO_ERR_NS = 30;
   // longest settle time of corrected data after data reaches the corrector
   localparam int T_DATA_TO_CORR_NS = 36;
   localparam int SYNC_STAGES = 2;
   // waits round up so the flag or data has surely settled
   localparam int ERR_WAIT_CYC = (T_DATA_TO_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CORR_WAIT_CYC = (T_DATA_TO_CORR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // state positions of the sequence
   // ----------------------------------------------------------------
   localparam int IDX_DATA_ON = 2;
   // decision index: data on bus, flag settles, flag crosses the synchroniser
   localparam int IDX_DECIDE = IDX_DATA_ON + ERR_WAIT_CYC + SYNC_STAGES;
   localparam int IDX_BUS_OFF = 7;
   localparam int IDX_OUT_LATCH = IDX_BUS_OFF + CORR_WAIT_CYC;
   localparam int IDX_EDC_DRIVE = 10;
   localparam int IDX_WRITE = 11;
   localparam int IDX_LAST_WRITE = 12;
   localparam int IDX_DONE = 13;

   // ----------------------------------------------------------------
   // lanes and reset values
   // ----------------------------------------------------------------
   localparam int LANES = 4;
   localparam logic [3:0] LANES_WIDE = 4'hf;
   localparam logic [3:0] LANES_NARROW = 4'h3;
   localparam logic [3:0] LANES_OFF_N = 4'hf;
   localparam logic INACTIVE_N = 1'b1;
   localparam logic INACTIVE = 1'b0;

   typedef enum logic [3:0] {
      ST_S0 = 4'h0,
      ST_S1 = 4'h1,
      ST_S2 = 4'h2,
      ST_S3 = 4'h3,
      ST_S4 = 4'h4,
      ST_S5 = 4'h5,
      ST_S6 = 4'h6,
      ST_S7 = 4'h7,
      ST_S8 = 4'h8,
      ST_S9 = 4'h9,
      ST_S10 = 4'ha,
      ST_S11 = 4'hb,
      ST_S12 = 4'hc,
      ST_S13 = 4'hd
   } emtc_state_t;

   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_MERGE = 2'h2
   } emtc_op_t;

endpackage : emtc_pkg

// ==== logic/emtc_sync.sv ====
`timescale 1ns/1ps
module emtc_sync
   import emtc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock, enable and reset
   input wire logic mclk,
   input wire logic ce,
   input wire logic rst_n,
   // asynchronous levels in, settled levels out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = meta;
      next_q = q;
      if (ce) begin
         next_meta = d;
         next_q = meta;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end

endmodule : emtc_sync

// ==== logic/emtc_lanes.sv ====
`timescale 1ns/1ps
module emtc_lanes
   import emtc_pkg::*;
(
   // clock, enable and reset
   input wire logic mclk,
   input wire logic ce,
   input wire logic rst_n,
   // drive windows for the coming state
   input wire logic win_host,
   input wire logic win_edc,
   input wire logic wide_path,
   input wire logic [LANES-1:0] lane_sel,
   // per-lane enables, active low
   output logic [LANES-1:0] host_lane_oe_n,
   output logic [LANES-1:0] edc_lane_oe_n
);

   logic [LANES-1:0] next_host_n;
   logic [LANES-1:0] next_edc_n;
   logic [LANES-1:0] present;

   // narrow path owns only the two low lanes
   assign present = wide_path ? LANES_WIDE : LANES_NARROW;

   genvar i;
   generate
      for (i = 0; i < LANES; i++) begin : g_lane
         always_comb begin
            next_host_n[i] = host_lane_oe_n[i];
            next_edc_n[i] = edc_lane_oe_n[i];
            if (ce) begin
               next_host_n[i] = ~(present[i] & win_host & lane_sel[i]);
               // the corrector lane is the complement, so a lane has one driver
               next_edc_n[i] = ~(present[i] & win_edc & ~(win_host & lane_sel[i]));
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_lane_oe_n <= LANES_OFF_N;
         edc_lane_oe_n <= LANES_OFF_N;
      end else begin
         host_lane_oe_n <= next_host_n;
         edc_lane_oe_n <= next_edc_n;
      end
   end

endmodule : emtc_lanes

// ==== logic/emtc_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// - check-only reads hand memory data straight to the host
// - check-only single error stretches the read, corrects, delivers, writes back
// - during that correction memory buffers go off, corrector drives the bus
// - host ack, ready and bus error come from the corrector's flags
// - stretch decision taken only from error flag after its settle time
// - correct-always sends every read word without a multiple error through correction and write-back
// - strobes finish the array read before state 7, data in input latch
// - correction spans states 7 to 12, result caught in output latch in states 7 to 9
// - corrector drives the shared bus no earlier than state 10
// - memory buffer enables stay high from state 7 while corrector drives
// - bus turnaround from inward to outward happens between states 6 and 10
// - bus that carried memory data is released before corrected data goes out
// - corrected word and new check bits are written back to the array
// - wide path gives four lane enables, inverted forms to the corrector
// - narrow path gives two lane enables, inverted forms to the corrector
// - one shared bus, only one driver enabled at a time
// - static RAM mode uses transceiver direction, no row or column strobes
// - state positions are typical and set by package constants
// - byte update reads and corrects first, then writes merged word and checks
module emtc_ctrl
   import emtc_pkg::*;
(
   // clock, enable and reset
   input wire logic mclk,
   input wire logic ce,
   input wire logic rst_n,
   // configuration levels
   input wire logic correct_always,
   input wire logic sram_mode,
   input wire logic wide_path,
   // host request
   input wire logic host_req_n,
   input wire logic host_wr,
   input wire logic [LANES-1:0] host_be,
   // correction device flags
   input wire logic edc_err_n,
   input wire logic edc_mult_err_n,
   // host termination
   output logic dtack_n,
   output logic ready,
   output logic berr_n,
   // array strobes
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic ram_sel_n,
   // buffers on the shared bus
   output logic memory_buffer_output_enable_n,
   output logic ram_buf_to_array,
   output logic host_rd_oe_n,
   output logic [LANES-1:0] host_lane_oe_n,
   // correction device control
   output logic [LANES-1:0] edc_lane_oe_n,
   output logic memory_data_in_latch,
   output logic corrected_data_out_latch,
   output logic edc_correct
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = LANES + 7;
   logic [SW-1:0] raw_in;
   logic [SW-1:0] syn_in;
   logic req_s;
   logic wr_s;
   logic err_s;
   logic mult_s;
   logic ca_s;
   logic sram_s;
   logic wide_s;
   logic [LANES-1:0] be_s;

   // flags inverted so an idle pin reads as zero through reset
   assign raw_in = {~host_req_n, host_wr, ~edc_err_n, ~edc_mult_err_n,
                    correct_always, sram_mode, wide_path, host_be};

   emtc_sync #(.WIDTH(SW)) u_sync (
      .mclk(mclk),
      .ce(ce),
      .rst_n(rst_n),
      .d(raw_in),
      .q(syn_in)
   );

   assign {req_s, wr_s, err_s, mult_s, ca_s, sram_s, wide_s, be_s} = syn_in;

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   function automatic logic in_span(emtc_state_t st, int lo, int hi);
      in_span = (int'(st) >= lo) && (int'(st) <= hi);
   endfunction : in_span

   function automatic logic [LANES-1:0] full_mask(logic wide);
      full_mask = wide ? LANES_WIDE : LANES_NARROW;
   endfunction : full_mask

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   emtc_state_t state;
   emtc_state_t next_state;
   emtc_op_t op;
   emtc_op_t next_op;
   logic ca;
   logic next_ca;
   logic sram;
   logic next_sram;
   logic wide;
   logic next_wide;
   logic fast;
   logic next_fast;
   logic bad;
   logic next_bad;
   logic [LANES-1:0] be;
   logic [LANES-1:0] next_be;

   always_comb begin
      next_state = state;
      next_op = op;
      next_ca = ca;
      next_sram = sram;
      next_wide = wide;
      next_fast = fast;
      next_bad = bad;
      next_be = be;
      if (ce) begin
         case (state)
            ST_S0: begin
               if (req_s) begin
                  next_state = ST_S1;
                  next_ca = ca_s;
                  next_sram = sram_s;
                  next_wide = wide_s;
                  next_be = be_s & full_mask(wide_s);
                  next_fast = 1'b0;
                  next_bad = 1'b0;
                  if (!wr_s) begin
                     next_op = OP_READ;
                  end else if ((be_s & full_mask(wide_s)) == full_mask(wide_s)) begin
                     next_op = OP_WRITE;
                  end else begin
                     // partial word: read and correct before merging
                     next_op = OP_MERGE;
                  end
               end
            end
            ST_S1: begin
               // a full write needs no read, it goes straight to the write states
               if (op == OP_WRITE) begin
                  next_state = ST_S11;
               end else begin
                  next_state = ST_S2;
               end
            end
            ST_S6: begin
               // flag has settled and crossed the synchroniser by now
               if (mult_s) begin
                  next_bad = 1'b1;
                  next_state = ST_S13;
               end else if (op == OP_READ && !ca && !err_s) begin
                  next_fast = 1'b1;
                  next_state = ST_S13;
               end else begin
                  next_state = ST_S7;
               end
            end
            ST_S13: begin
               // hold the termination until the host withdraws its request
               if (!req_s) begin
                  next_state = ST_S0;
               end
            end
            default: begin
               if (int'(state) < IDX_DONE) begin
                  next_state = emtc_state_t'(state + 4'h1);
               end else begin
                  next_state = ST_S0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= ST_S0;
         op <= OP_READ;
         ca <= INACTIVE;
         sram <= INACTIVE;
         wide <= INACTIVE;
         fast <= INACTIVE;
         bad <= INACTIVE;
         be <= '0;
      end else begin
         state <= next_state;
         op <= next_op;
         ca <= next_ca;
         sram <= next_sram;
         wide <= next_wide;
         fast <= next_fast;
         bad <= next_bad;
         be <= next_be;
      end
   end

   // ----------------------------------------------------------------
   // output decode, registered one state ahead
   // ----------------------------------------------------------------
   logic rd_op;
   logic active;
   logic mem_read;
   logic write_back;
   logic edc_win;
   logic host_win;
   logic next_dtack_n;
   logic next_berr_n;
   logic next_ras_n;
   logic next_cas_n;
   logic next_we_n;
   logic next_sel_n;
   logic next_mbuf_n;
   logic next_to_array;
   logic next_host_rd_n;
   logic next_in_latch;
   logic next_out_latch;
   logic next_correct;

   always_comb begin
      rd_op = (next_op != OP_WRITE);
      active = in_span(next_state, 1, IDX_LAST_WRITE) ||
               (next_state == ST_S13 && next_fast);
      // memory drives inward only until the turnaround starts
      mem_read = rd_op && (in_span(next_state, IDX_DATA_ON, IDX_DECIDE) ||
                 (next_state == ST_S13 && next_fast));
      write_back = in_span(next_state, IDX_WRITE, IDX_LAST_WRITE);
      // corrector output waits for the quiet turnaround states
      edc_win = rd_op && !next_bad && (in_span(next_state, IDX_EDC_DRIVE, IDX_LAST_WRITE) ||
                (next_state == ST_S13 && next_op == OP_READ && !next_fast));
      host_win = !rd_op ? (next_state == ST_S1 || write_back) :
                 (next_op == OP_MERGE && write_back);

      next_dtack_n = dtack_n;
      next_berr_n = berr_n;
      next_ras_n = ras_n;
      next_cas_n = cas_n;
      next_we_n = we_n;
      next_sel_n = ram_sel_n;
      next_mbuf_n = memory_buffer_output_enable_n;
      next_to_array = ram_buf_to_array;
      next_host_rd_n = host_rd_oe_n;
      next_in_latch = memory_data_in_latch;
      next_out_latch = corrected_data_out_latch;
      next_correct = edc_correct;
      if (ce) begin
         // static RAM has no row or column strobes, only a select
         next_ras_n = ~(active && !next_sram);
         next_cas_n = ~(active && !next_sram && int'(next_state) >= IDX_DATA_ON);
         next_sel_n = ~(active && next_sram);
         next_we_n = ~write_back;
         next_mbuf_n = ~mem_read;
         next_to_array = next_sram && write_back;
         // direct path in check-only, corrected path otherwise
         next_host_rd_n = ~(next_op == OP_READ && !next_bad &&
                           ((!next_ca && in_span(next_state, IDX_DATA_ON + 1, IDX_DECIDE)) ||
                            (next_state == ST_S13 && next_fast) ||
                            edc_win));
         next_in_latch = rd_op && in_span(next_state, IDX_DATA_ON, IDX_DECIDE);
         next_out_latch = rd_op && in_span(next_state, IDX_BUS_OFF, IDX_OUT_LATCH);
         next_correct = rd_op && in_span(next_state, IDX_BUS_OFF, IDX_LAST_WRITE);
         next_dtack_n = ~(next_state == ST_S13 && !next_bad);
         next_berr_n = ~(next_state == ST_S13 && next_bad);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dtack_n <= INACTIVE_N;
         berr_n <= INACTIVE_N;
         ras_n <= INACTIVE_N;
         cas_n <= INACTIVE_N;
         we_n <= INACTIVE_N;
         ram_sel_n <= INACTIVE_N;
         memory_buffer_output_enable_n <= INACTIVE_N;
         ram_buf_to_array <= INACTIVE;
         host_rd_oe_n <= INACTIVE_N;
         memory_data_in_latch <= INACTIVE;
         corrected_data_out_latch <= INACTIVE;
         edc_correct <= INACTIVE;
      end else begin
         dtack_n <= next_dtack_n;
         berr_n <= next_berr_n;
         ras_n <= next_ras_n;
         cas_n <= next_cas_n;
         we_n <= next_we_n;
         ram_sel_n <= next_sel_n;
         memory_buffer_output_enable_n <= next_mbuf_n;
         ram_buf_to_array <= next_to_array;
         host_rd_oe_n <= next_host_rd_n;
         memory_data_in_latch <= next_in_latch;
         corrected_data_out_latch <= next_out_latch;
         edc_correct <= next_correct;
      end
   end

   assign ready = ~dtack_n;

   // ----------------------------------------------------------------
   // lane enables
   // ----------------------------------------------------------------
   emtc_lanes u_lanes (
      .mclk(mclk),
      .ce(ce),
      .rst_n(rst_n),
      .win_host(host_win),
      .win_edc(edc_win),
      .wide_path(next_wide),
      .lane_sel(next_be),
      .host_lane_oe_n(host_lane_oe_n),
      .edc_lane_oe_n(edc_lane_oe_n)
   );

endmodule : emtc_ctrl

// ==== verif/emtc_edc_model.sv ====
`timescale 1ns/1ps
module emtc_edc_model
   import emtc_pkg::*;
(
   // clock
   input wire logic mclk,
   // input latch control from the controller
   input wire logic memory_data_in_latch,
   // commanded fault: 0 none, 1 single, 2 multiple; slow delays the flag a cycle
   input wire logic [1:0] fault,
   input wire logic slow,
   // flags, active low
   output logic edc_err_n,
   output logic edc_mult_err_n
);
   // ------
   // flags
   // ------
   logic seen;
   logic flag_on;
   initial begin
      seen = 1'b0;
      edc_err_n = 1'b1;
      edc_mult_err_n = 1'b1;
   end
   // flags only mean something while the latch holds a word; idle level is high
   assign flag_on = memory_data_in_latch && (!slow || seen);
   always @(negedge mclk) begin
      seen <= memory_data_in_latch;
      edc_err_n <= !(flag_on && fault != 2'h0);
      edc_mult_err_n <= !(flag_on && fault == 2'h2);
   end
endmodule : emtc_edc_model

// ==== verif/emtc_ctrl_assertions.sv ====
`timescale 1ns/1ps
module emtc_ctrl_chk
   import emtc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // levels and request
   input wire logic sram_mode,
   input wire logic wide_path,
   input wire logic host_req_n,
   // controller outputs
   input wire logic dtack_n,
   input wire logic ready,
   input wire logic berr_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic memory_buffer_output_enable_n,
   input wire logic host_rd_oe_n,
   input wire logic [LANES-1:0] host_lane_oe_n,
   input wire logic [LANES-1:0] edc_lane_oe_n,
   input wire logic memory_data_in_latch,
   input wire logic corrected_data_out_latch
);
   // ------
   // checks
   // ------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_one_driver: assert property (!memory_buffer_output_enable_n |-> edc_lane_oe_n == 4'hf)
      else $error("memory buffer and corrector drive together");
   a_edc_late: assert property ($fell(&edc_lane_oe_n) |-> $past(corrected_data_out_latch)
      && $past(memory_buffer_output_enable_n) && $past(memory_buffer_output_enable_n, 2)
      && $past(memory_buffer_output_enable_n, 3)) else $error("corrector drove too early");
   a_we_pulse: assert property ($fell(we_n) |=> !we_n ##1 we_n)
      else $error("write-back pulse length wrong");
   a_ack_after_we: assert property ($fell(we_n) |-> ##2 !dtack_n)
      else $error("no ack after write-back");
   a_berr_nowrite: assert property (!berr_n |-> we_n && dtack_n)
      else $error("uncorrectable word written or acked");
   a_ready_mirror: assert property (ready == !dtack_n)
      else $error("ready disagrees with ack");
   a_ack_holds: assert property (!dtack_n && !host_req_n && !$past(host_req_n)
      && !$past(host_req_n, 2) |=> !dtack_n) else $error("ack dropped under request");
   a_out_window: assert property ($rose(corrected_data_out_latch)
      |-> corrected_data_out_latch [*3] ##1 !corrected_data_out_latch)
      else $error("output latch window wrong");
   a_in_then_out: assert property ($rose(corrected_data_out_latch)
      |-> $past(memory_data_in_latch) && !memory_data_in_latch)
      else $error("input latch not closed before correction");
   a_sram_nostrobe: assert property (sram_mode && $past(sram_mode) |-> ras_n && cas_n)
      else $error("row or column strobe in static mode");
   a_narrow_lanes: assert property (!wide_path && !$past(wide_path)
      |-> host_lane_oe_n[3:2] == 2'b11 && edc_lane_oe_n[3:2] == 2'b11)
      else $error("upper lanes used on narrow path");
   a_lane_split: assert property ((~host_lane_oe_n & ~edc_lane_oe_n) == 4'h0)
      else $error("lane driven by host and corrector");
   a_rd_no_write: assert property (!host_rd_oe_n |-> host_lane_oe_n == 4'hf)
      else $error("host read and write buffers both on");
endmodule : emtc_ctrl_chk

bind emtc_ctrl emtc_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .sram_mode(sram_mode),
   .wide_path(wide_path), .host_req_n(host_req_n), .dtack_n(dtack_n), .ready(ready),
   .berr_n(berr_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
   .memory_buffer_output_enable_n(memory_buffer_output_enable_n),
   .host_rd_oe_n(host_rd_oe_n), .host_lane_oe_n(host_lane_oe_n),
   .edc_lane_oe_n(edc_lane_oe_n), .memory_data_in_latch(memory_data_in_latch),
   .corrected_data_out_latch(corrected_data_out_latch));

// ==== verif/emtc_ctrl_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
module emtc_ctrl_test
   import emtc_pkg::*;
;
   // ------
   // signals
   // ------
   logic mclk, ce, rst_n, correct_always, sram_mode, wide_path, host_req_n, host_wr;
   logic [3:0] host_be, host_lane_oe_n, edc_lane_oe_n;
   logic edc_err_n, edc_mult_err_n, dtack_n, ready, berr_n, ras_n, cas_n, we_n, ram_sel_n;
   logic memory_buffer_output_enable_n, ram_buf_to_array, host_rd_oe_n, edc_correct;
   logic memory_data_in_latch, corrected_data_out_latch, slow;
   logic [1:0] fault;
   logic [31:0] seed;
   int bad_count, cmp_count;

   emtc_ctrl dut (.mclk(mclk), .ce(ce), .rst_n(rst_n), .correct_always(correct_always),
      .sram_mode(sram_mode), .wide_path(wide_path), .host_req_n(host_req_n),
      .host_wr(host_wr), .host_be(host_be), .edc_err_n(edc_err_n),
      .edc_mult_err_n(edc_mult_err_n), .dtack_n(dtack_n), .ready(ready), .berr_n(berr_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ram_sel_n(ram_sel_n),
      .memory_buffer_output_enable_n(memory_buffer_output_enable_n),
      .ram_buf_to_array(ram_buf_to_array), .host_rd_oe_n(host_rd_oe_n),
      .host_lane_oe_n(host_lane_oe_n), .edc_lane_oe_n(edc_lane_oe_n),
      .memory_data_in_latch(memory_data_in_latch),
      .corrected_data_out_latch(corrected_data_out_latch), .edc_correct(edc_correct));

   emtc_edc_model u_edc (.mclk(mclk), .memory_data_in_latch(memory_data_in_latch),
      .fault(fault), .slow(slow), .edc_err_n(edc_err_n), .edc_mult_err_n(edc_mult_err_n));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ------
   // helpers
   // ------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // states from take to ack
   function automatic int exp_lat(input logic ca, wr, input logic [3:0] be, pres,
                                  input logic [1:0] flt);
      if (wr && be == pres) return 4;
      if (flt == 2'h2 || (!wr && !ca && flt == 2'h0)) return 7;
      return 13;
   endfunction : exp_lat

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic do_reset;
      rst_n = 1'b0;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
   endtask : do_reset

   // c = {slow, fault, be, wr, wide, sram, correct_always}; called at a falling edge
   task automatic run_op(input logic [11:0] c, input int frz);
      int n, lat, wlo, rlo, blo, slo, clo;
      logic [3:0] pres;
      logic fast;
      pres = c[2] ? 4'hf : 4'h3;
      lat = exp_lat(c[0], c[3], c[7:4] & pres, pres, c[9:8]);
      fast = lat == 7;
      {slow, fault, host_be, host_wr, wide_path, sram_mode, correct_always} = c[10:0];
      host_req_n = 1'b0;
      n = 0;
      wlo = 0;
      rlo = 0;
      blo = 0;
      slo = 0;
      clo = 0;
      while (dtack_n === 1'b1 && berr_n === 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
         if (n == 4 && frz > 0) ce <= 1'b0;
         if (n == 4 + frz) ce <= 1'b1;
         #1;
         wlo += int'(we_n === 1'b0);
         rlo += int'(ras_n === 1'b0);
         blo += int'(ram_buf_to_array === 1'b1);
         slo += int'(ram_sel_n === 1'b0);
         clo += int'(edc_correct === 1'b1);
      end
      if (n >= 40) begin
         bad_count++;
         stop_test;
      end
      `CHK(n, lat + 2 + frz)
      `CHK(ready, c[9:8] != 2'h2)
      `CHK(berr_n, c[9:8] != 2'h2)
      `CHK(wlo, fast ? 0 : 2)
      `CHK(rlo == 0, c[1])
      `CHK(blo, (c[1] && !fast) ? 2 : 0)
      `CHK(slo, c[1] ? ((fast && c[9:8] != 2'h2) ? lat : lat - 1) : 0)
      `CHK(clo, (fast || lat == 4) ? 0 : IDX_LAST_WRITE - IDX_BUS_OFF + 1)
      if (c[9:8] != 2'h2) `CHK(memory_buffer_output_enable_n, !fast)
      if (!c[3]) `CHK(edc_lane_oe_n, fast ? 4'hf : ~pres)
      if (!c[3]) `CHK(host_rd_oe_n, c[9:8] == 2'h2)
      @(negedge mclk);
      host_req_n = 1'b1;
      fault = 2'h0;
      n = 0;
      while ((dtack_n !== 1'b1 || berr_n !== 1'b1) && n < 10) begin
         @(posedge mclk);
         n++;
         #1;
      end
      if (n >= 10) begin
         bad_count++;
         stop_test;
      end
      `CHK({ras_n, cas_n, we_n, memory_buffer_output_enable_n, host_rd_oe_n}, 5'h1f)
      `CHK({host_lane_oe_n, edc_lane_oe_n}, 8'hff)
      @(negedge mclk);
   endtask : run_op

   // ------
   // sequence
   // ------
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      {correct_always, sram_mode, wide_path, host_wr, slow} = 5'h04;
      host_req_n = 1'b1;
      host_be = 4'h0;
      fault = 2'h0;
      bad_count = 0;
      cmp_count = 0;
      seed = 32'h0000_6191;
      @(negedge mclk);
      do_reset;
      @(negedge mclk);
      // corner cases first: clean, slow single, fatal, always, writes, merge, freeze
      run_op(12'h0f4, 0);
      run_op(12'h530, 0);
      run_op(12'h2f6, 0);
      run_op(12'h0f7, 0);
      run_op(12'h0fc, 0);
      run_op(12'h12d, 0);
      run_op(12'h0f8, 0);
      run_op(12'h0f4, 3);
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         run_op((seed[11:0] | 12'h010) & 12'h5ff, 0);
      end
      // reset in mid-cycle returns everything to idle
      host_req_n = 1'b0;
      repeat (8) @(negedge mclk);
      host_req_n = 1'b1;
      do_reset;
      `CHK({dtack_n, berr_n, we_n, memory_buffer_output_enable_n, ras_n}, 5'h1f)
      run_op(12'h0f4, 0);
      stop_test;
   end
endmodule : emtc_ctrl_test
